// ---- rtl/tpg_params.svh ----
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH

// =====================================================================
// widths
`define TPG_SAMPLE_W 14
`define TPG_CODE_W 4
`define TPG_REG_W 8
`define TPG_APB_AW 10
`define TPG_APB_DW 32

// =====================================================================
// register indices; byte address is four times the index
`define TPG_IDX_GAIN_EN_A 8'h03
`define TPG_IDX_GAIN_EN_B 8'h04
`define TPG_IDX_PAT_CTRL 8'h06
`define TPG_IDX_PAT_SEL_A 8'h0A
`define TPG_IDX_PAT_SEL_B 8'h0B
`define TPG_IDX_GAIN_SEL_A 8'h0C
`define TPG_IDX_GAIN_SEL_B 8'h0D
`define TPG_IDX_CUSTOM_HI 8'h0E
`define TPG_IDX_CUSTOM_LO 8'h0F

// =====================================================================
// field positions
`define TPG_GAIN_EN_BIT 1
`define TPG_PAT_EN_BIT 1
`define TPG_SOFT_RST_BIT 0
`define TPG_CODE_A_LSB 0
`define TPG_CODE_B_LSB 4
`define TPG_CUSTOM_LO_LSB 2

// =====================================================================
// reset values
`define TPG_RST_REG 8'h00
`define TPG_RST_CODE 4'h0
`define TPG_RST_WORD 14'h0000
`define TPG_RST_LFSR 23'h7FFFFF

// =====================================================================
// fixed pattern words
`define TPG_ALL_ONES 14'h3FFF
`define TPG_TOGGLE_WORD 14'h2AAA
`define TPG_DESKEW_WORD 14'h3AAA
`define TPG_RAMP_MAX 14'h3FFF
`define TPG_SINE_0 14'h0000
`define TPG_SINE_1 14'h095F
`define TPG_SINE_2 14'h2000
`define TPG_SINE_3 14'h36A0
`define TPG_SINE_4 14'h3FFF

// =====================================================================
// gain factors, unsigned 2.12 fixed point, 0.5 dB per code
`define TPG_GAIN_FRAC 12
`define TPG_GAIN_MAX_CODE 4'hC
`define TPG_GAIN_0 14'h1000
`define TPG_GAIN_1 14'h10F3
`define TPG_GAIN_2 14'h11F4
`define TPG_GAIN_3 14'h1304
`define TPG_GAIN_4 14'h1425
`define TPG_GAIN_5 14'h1556
`define TPG_GAIN_6 14'h169A
`define TPG_GAIN_7 14'h17F1
`define TPG_GAIN_8 14'h195C
`define TPG_GAIN_9 14'h1ADC
`define TPG_GAIN_10 14'h1C74
`define TPG_GAIN_11 14'h1E23
`define TPG_GAIN_12 14'h1FED
`define TPG_SAT_POS 14'h1FFF
`define TPG_SAT_NEG 14'h2000

`endif

// ---- rtl/tpg_pkg.sv ----
package tpg_pkg;

   // =====================================================================
   // pattern selection codes
   typedef enum logic [3:0] {
      PAT_NORMAL = 4'h0,
      PAT_ZEROS = 4'h1,
      PAT_ONES = 4'h2,
      PAT_TOGGLE = 4'h3,
      PAT_RAMP = 4'h4,
      PAT_CUSTOM = 4'h5,
      PAT_DESKEW = 4'h6,
      PAT_PRBS = 4'h8,
      PAT_SINE = 4'h9
   } tpg_pat_code_t;

   typedef logic [13:0] tpg_word_t;

endpackage

// ---- rtl/tpg_gen_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// shared pattern words from the generator to the channel muxes
interface tpg_gen_if;
   tpg_pkg::tpg_word_t ramp;
   tpg_pkg::tpg_word_t toggle;
   tpg_pkg::tpg_word_t prbs;
   tpg_pkg::tpg_word_t sine;

   modport gen (output ramp, output toggle, output prbs, output sine);
   modport use_side (input ramp, input toggle, input prbs, input sine);
endinterface

`default_nettype wire

// ---- rtl/tpg_pattern_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tpg_params.svh"

// =====================================================================
// free-running generators, shared by both channels so they stay aligned
module tpg_pattern_gen (
   input wire logic clk,
   input wire logic rst,
   tpg_gen_if.gen gen
);
   logic [13:0] ramp_q, ramp_d;
   logic toggle_q, toggle_d;
   logic [2:0] sine_idx_q, sine_idx_d;
   logic [22:0] lfsr_q, lfsr_d;

   always_comb begin
      // ramp wraps from full scale back to zero
      ramp_d = (ramp_q == `TPG_RAMP_MAX) ? `TPG_RST_WORD : ramp_q + 14'h0001;
      toggle_d = ~toggle_q;
      sine_idx_d = sine_idx_q + 3'h1;
      // x^23 + x^18 + 1, advanced 14 steps so each sample is fresh
      lfsr_d = lfsr_q;
      for (int i = 0; i < 14; i++) begin
         lfsr_d = {lfsr_d[21:0], lfsr_d[22] ^ lfsr_d[17]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ramp_q <= `TPG_RST_WORD;
         toggle_q <= 1'b0;
         sine_idx_q <= 3'h0;
         lfsr_q <= `TPG_RST_LFSR;
      end else begin
         ramp_q <= ramp_d;
         toggle_q <= toggle_d;
         sine_idx_q <= sine_idx_d;
         lfsr_q <= lfsr_d;
      end
   end

   assign gen.ramp = ramp_q;
   assign gen.toggle = toggle_q ? ~`TPG_TOGGLE_WORD : `TPG_TOGGLE_WORD;
   assign gen.prbs = lfsr_q[13:0];

   always_comb begin
      unique case (sine_idx_q)
         3'h0: gen.sine = `TPG_SINE_0;
         3'h1: gen.sine = `TPG_SINE_1;
         3'h2: gen.sine = `TPG_SINE_2;
         3'h3: gen.sine = `TPG_SINE_3;
         3'h4: gen.sine = `TPG_SINE_4;
         3'h5: gen.sine = `TPG_SINE_3;
         3'h6: gen.sine = `TPG_SINE_2;
         3'h7: gen.sine = `TPG_SINE_1;
      endcase
   end
endmodule

`default_nettype wire

// ---- rtl/tpg_gain.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tpg_params.svh"

// =====================================================================
// digital gain on a two's complement sample, saturating
module tpg_gain (
   input wire logic [13:0] sample,
   input wire logic [3:0] code,
   input wire logic enable,
   output logic [13:0] result
);
   logic [13:0] factor;
   logic signed [28:0] product;
   logic signed [16:0] scaled;

   always_comb begin
      unique case (code)
         4'h0: factor = `TPG_GAIN_0;
         4'h1: factor = `TPG_GAIN_1;
         4'h2: factor = `TPG_GAIN_2;
         4'h3: factor = `TPG_GAIN_3;
         4'h4: factor = `TPG_GAIN_4;
         4'h5: factor = `TPG_GAIN_5;
         4'h6: factor = `TPG_GAIN_6;
         4'h7: factor = `TPG_GAIN_7;
         4'h8: factor = `TPG_GAIN_8;
         4'h9: factor = `TPG_GAIN_9;
         4'hA: factor = `TPG_GAIN_10;
         4'hB: factor = `TPG_GAIN_11;
         // codes above 6 dB are undefined; hold at the top step
         default: factor = `TPG_GAIN_12;
      endcase
      product = 29'($signed(sample) * $signed({1'b0, factor}));
      scaled = product[28:12];
      if (!enable) begin
         result = sample;
      end else if (scaled > 17'sh01FFF) begin
         result = `TPG_SAT_POS;
      end else if (scaled < -17'sh02000) begin
         result = `TPG_SAT_NEG;
      end else begin
         result = scaled[13:0];
      end
   end
endmodule

`default_nettype wire

// ---- rtl/tpg_top.sv ----
// Contract
// - channel A pattern code in bits 3-0, used only while enable set
// - channel B pattern code in bits 7-4, same codes as A
// - code 0000 passes normal samples unchanged; the code still applies the channel gain to them when that gain is enabled
// - code 0011 alternates 10101... word and its complement
// - code 0100 ramps up by one per sample, 0 to 16383
// - code 0101 outputs the programmed custom word every sample
// - code 0110 outputs constant 3AAAh
// - code 1000 outputs a new pseudo-random value each sample
// - code 1001 repeats the eight-point sine sequence
// - channel A gain code in bits 3-0 sets its digital gain
// - gain code steps 0.5 dB, 0000 is 0 dB, 1100 is 6 dB
// - channel B gain code in bits 7-4, same mapping as A
// - global pattern enable must be set; clear means normal data
// - per-channel gain enable; gain applied only when set
// - shared custom word: [13:6] one register, [5:0] bits 7-2 next
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tpg_params.svh"

module tpg_top (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [9:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [13:0] SAMPLE_A_IN,
   input wire logic [13:0] SAMPLE_B_IN,
   output logic [13:0] SAMPLE_A_OUT,
   output logic [13:0] SAMPLE_B_OUT
);

   // =====================================================================
   // configuration state
   logic gain_en_a_q, gain_en_a_d;
   logic gain_en_b_q, gain_en_b_d;
   logic pat_en_q, pat_en_d;
   logic [3:0] chan_a_pattern_code_q, chan_a_pattern_code_d;
   logic [3:0] chan_b_pattern_code_q, chan_b_pattern_code_d;
   logic [3:0] chan_a_gain_code_q, chan_a_gain_code_d;
   logic [3:0] chan_b_gain_code_q, chan_b_gain_code_d;
   logic [7:0] custom_hi_q, custom_hi_d;
   logic [5:0] custom_lo_q, custom_lo_d;

   // =====================================================================
   // bus state
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;

   // =====================================================================
   // decode
   logic [7:0] reg_idx;
   logic aligned;
   logic hit;
   logic access;
   logic wr_commit;
   logic lane0;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic soft_rst;

   assign reg_idx = PADDR[9:2];
   assign aligned = (PADDR[1:0] == 2'h0);
   assign lane0 = PSTRB[0];
   assign wbyte = PWDATA[7:0];
   assign access = PSEL & PENABLE;
   // a write lands only at the edge where the master sees pready high
   assign wr_commit = access & pready_q & PWRITE & ~pslverr_q & lane0;

   always_comb begin
      hit = 1'b0;
      rbyte = `TPG_RST_REG;
      if (aligned) begin
         unique case (reg_idx)
            `TPG_IDX_GAIN_EN_A: begin
               hit = 1'b1;
               rbyte[`TPG_GAIN_EN_BIT] = gain_en_a_q;
            end
            `TPG_IDX_GAIN_EN_B: begin
               hit = 1'b1;
               rbyte[`TPG_GAIN_EN_BIT] = gain_en_b_q;
            end
            `TPG_IDX_PAT_CTRL: begin
               hit = 1'b1;
               // the reset bit self-clears, so it always reads as zero
               rbyte[`TPG_PAT_EN_BIT] = pat_en_q;
            end
            `TPG_IDX_PAT_SEL_A: begin
               hit = 1'b1;
               rbyte[3:0] = chan_a_pattern_code_q;
            end
            `TPG_IDX_PAT_SEL_B: begin
               hit = 1'b1;
               rbyte[7:4] = chan_b_pattern_code_q;
            end
            `TPG_IDX_GAIN_SEL_A: begin
               hit = 1'b1;
               rbyte[3:0] = chan_a_gain_code_q;
            end
            `TPG_IDX_GAIN_SEL_B: begin
               hit = 1'b1;
               rbyte[7:4] = chan_b_gain_code_q;
            end
            `TPG_IDX_CUSTOM_HI: begin
               hit = 1'b1;
               rbyte = custom_hi_q;
            end
            `TPG_IDX_CUSTOM_LO: begin
               hit = 1'b1;
               rbyte[7:2] = custom_lo_q;
            end
            default: begin
               hit = 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // apb slave: one wait state, answer registered
   always_comb begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (access & ~pready_q) begin
         pready_d = 1'b1;
         pslverr_d = ~hit;
         prdata_d = {24'h000000, rbyte};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;

   // =====================================================================
   // register file
   assign soft_rst = wr_commit & (reg_idx == `TPG_IDX_PAT_CTRL) &
                     wbyte[`TPG_SOFT_RST_BIT];

   always_comb begin
      gain_en_a_d = gain_en_a_q;
      gain_en_b_d = gain_en_b_q;
      pat_en_d = pat_en_q;
      chan_a_pattern_code_d = chan_a_pattern_code_q;
      chan_b_pattern_code_d = chan_b_pattern_code_q;
      chan_a_gain_code_d = chan_a_gain_code_q;
      chan_b_gain_code_d = chan_b_gain_code_q;
      custom_hi_d = custom_hi_q;
      custom_lo_d = custom_lo_q;
      if (soft_rst) begin
         // software reset returns every field to its default
         gain_en_a_d = 1'b0;
         gain_en_b_d = 1'b0;
         pat_en_d = 1'b0;
         chan_a_pattern_code_d = `TPG_RST_CODE;
         chan_b_pattern_code_d = `TPG_RST_CODE;
         chan_a_gain_code_d = `TPG_RST_CODE;
         chan_b_gain_code_d = `TPG_RST_CODE;
         custom_hi_d = `TPG_RST_REG;
         custom_lo_d = 6'h00;
      end else if (wr_commit) begin
         unique case (reg_idx)
            `TPG_IDX_GAIN_EN_A: begin
               gain_en_a_d = wbyte[`TPG_GAIN_EN_BIT];
            end
            `TPG_IDX_GAIN_EN_B: begin
               gain_en_b_d = wbyte[`TPG_GAIN_EN_BIT];
            end
            `TPG_IDX_PAT_CTRL: begin
               pat_en_d = wbyte[`TPG_PAT_EN_BIT];
            end
            `TPG_IDX_PAT_SEL_A: begin
               chan_a_pattern_code_d = wbyte[3:0];
            end
            `TPG_IDX_PAT_SEL_B: begin
               chan_b_pattern_code_d = wbyte[7:4];
            end
            `TPG_IDX_GAIN_SEL_A: begin
               chan_a_gain_code_d = wbyte[3:0];
            end
            `TPG_IDX_GAIN_SEL_B: begin
               chan_b_gain_code_d = wbyte[7:4];
            end
            `TPG_IDX_CUSTOM_HI: begin
               custom_hi_d = wbyte;
            end
            `TPG_IDX_CUSTOM_LO: begin
               custom_lo_d = wbyte[7:2];
            end
            default: begin
               custom_lo_d = custom_lo_q;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         gain_en_a_q <= 1'b0;
         gain_en_b_q <= 1'b0;
         pat_en_q <= 1'b0;
         chan_a_pattern_code_q <= `TPG_RST_CODE;
         chan_b_pattern_code_q <= `TPG_RST_CODE;
         chan_a_gain_code_q <= `TPG_RST_CODE;
         chan_b_gain_code_q <= `TPG_RST_CODE;
         custom_hi_q <= `TPG_RST_REG;
         custom_lo_q <= 6'h00;
      end else begin
         gain_en_a_q <= gain_en_a_d;
         gain_en_b_q <= gain_en_b_d;
         pat_en_q <= pat_en_d;
         chan_a_pattern_code_q <= chan_a_pattern_code_d;
         chan_b_pattern_code_q <= chan_b_pattern_code_d;
         chan_a_gain_code_q <= chan_a_gain_code_d;
         chan_b_gain_code_q <= chan_b_gain_code_d;
         custom_hi_q <= custom_hi_d;
         custom_lo_q <= custom_lo_d;
      end
   end

   // =====================================================================
   // shared generators
   tpg_gen_if gen_bus ();

   tpg_pattern_gen u_gen (
      .clk(CLK_SYS),
      .rst(RST),
      .gen(gen_bus.gen)
   );

   // =====================================================================
   // per-channel gain and pattern selection
   logic [13:0] sample_in [2];
   logic [3:0] pat_code [2];
   logic [3:0] gain_code [2];
   logic gain_en [2];
   logic [13:0] out_q [2];
   logic [13:0] out_d [2];
   tpg_pkg::tpg_word_t custom_word;

   assign custom_word = {custom_hi_q, custom_lo_q};
   assign sample_in[0] = SAMPLE_A_IN;
   assign sample_in[1] = SAMPLE_B_IN;
   assign pat_code[0] = chan_a_pattern_code_q;
   assign pat_code[1] = chan_b_pattern_code_q;
   assign gain_code[0] = chan_a_gain_code_q;
   assign gain_code[1] = chan_b_gain_code_q;
   assign gain_en[0] = gain_en_a_q;
   assign gain_en[1] = gain_en_b_q;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [13:0] gained;

      // gain acts on converted data only, never on test patterns
      tpg_gain u_gain (
         .sample(sample_in[ch]),
         .code(gain_code[ch]),
         .enable(gain_en[ch]),
         .result(gained)
      );

      always_comb begin
         out_d[ch] = gained;
         if (pat_en_q) begin
            unique case (pat_code[ch])
               tpg_pkg::PAT_NORMAL: out_d[ch] = gained;
               tpg_pkg::PAT_ZEROS: out_d[ch] = `TPG_RST_WORD;
               tpg_pkg::PAT_ONES: out_d[ch] = `TPG_ALL_ONES;
               tpg_pkg::PAT_TOGGLE: out_d[ch] = gen_bus.toggle;
               tpg_pkg::PAT_RAMP: out_d[ch] = gen_bus.ramp;
               tpg_pkg::PAT_CUSTOM: out_d[ch] = custom_word;
               tpg_pkg::PAT_DESKEW: out_d[ch] = `TPG_DESKEW_WORD;
               tpg_pkg::PAT_PRBS: out_d[ch] = gen_bus.prbs;
               tpg_pkg::PAT_SINE: out_d[ch] = gen_bus.sine;
               // unlisted codes fall back to normal data
               default: out_d[ch] = gained;
            endcase
         end
      end

      always_ff @(posedge CLK_SYS) begin
         if (RST) begin
            out_q[ch] <= `TPG_RST_WORD;
         end else begin
            out_q[ch] <= out_d[ch];
         end
      end
   end

   assign SAMPLE_A_OUT = out_q[0];
   assign SAMPLE_B_OUT = out_q[1];

endmodule

`default_nettype wire

// ---- testbench/tpg_sample_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// converter stand-in: two full-period walks, so both signs and the
// saturation ends of the gain are reached
module tpg_sample_src (
   input wire logic clk,
   output logic [13:0] sample_a,
   output logic [13:0] sample_b,
   output logic [13:0] prev_a,
   output logic [13:0] prev_b
);
   initial begin
      sample_a = 14'h0000;
      sample_b = 14'h1000;
   end
   always @(posedge clk) begin
      prev_a <= sample_a;
      prev_b <= sample_b;
      sample_a <= sample_a * 14'h0005 + 14'h0ECB;
      sample_b <= sample_b * 14'h000D + 14'h1F31;
   end
endmodule
`default_nettype wire

// ---- testbench/tpg_top_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// bus handshake and channel A output checks
module tpg_top_properties (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [9:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [13:0] SAMPLE_A_IN,
   input wire logic [13:0] SAMPLE_B_IN,
   input wire logic [13:0] SAMPLE_A_OUT,
   input wire logic [13:0] SAMPLE_B_OUT
);
   logic wr, pat_d, pat_q, gain_d, gain_q, ramp_on, tog_on, sine_on;
   logic [3:0] code_d, code_q;
   // shadow of channel A config, rebuilt from committed writes only
   assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PSLVERR;
   assign ramp_on = pat_q && code_q == 4'h4;
   assign tog_on = pat_q && code_q == 4'h3;
   assign sine_on = pat_q && code_q == 4'h9;
   always_comb begin
      pat_d = pat_q;
      gain_d = gain_q;
      code_d = code_q;
      if (wr && PADDR == 10'h018 && PWDATA[0]) begin
         pat_d = 1'h0;
         gain_d = 1'h0;
         code_d = 4'h0;
      end else if (wr) begin
         pat_d = PADDR == 10'h018 ? PWDATA[1] : pat_q;
         gain_d = PADDR == 10'h00C ? PWDATA[1] : gain_q;
         code_d = PADDR == 10'h028 ? PWDATA[3:0] : code_q;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pat_q <= 1'h0;
         gain_q <= 1'h0;
         code_q <= 4'h0;
      end else begin
         pat_q <= pat_d;
         gain_q <= gain_d;
         code_q <= code_d;
      end
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_wait;
      PSEL && PENABLE && !PREADY;
   endsequence
   a_ready_wait: assert property (s_setup ##1 s_wait |=> PREADY)
      else $error("ready missing after one wait state");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   a_ready_idle: assert property (!PSEL |=> !PREADY)
      else $error("ready without a transfer");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_read_upper: assert property (PRDATA[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_normal_pass: assert property (!pat_q && !gain_q |=>
      SAMPLE_A_OUT == $past(SAMPLE_A_IN)) else $error("normal data altered");
   a_ramp_step: assert property (ramp_on ##1 ramp_on |=>
      SAMPLE_A_OUT == $past(SAMPLE_A_OUT) + 14'h0001) else $error("bad ramp");
   a_toggle_flip: assert property (tog_on ##1 tog_on |=>
      SAMPLE_A_OUT == ~$past(SAMPLE_A_OUT)) else $error("toggle not flipped");
   a_deskew_word: assert property (pat_q && code_q == 4'h6 |=>
      SAMPLE_A_OUT == 14'h3AAA) else $error("deskew word wrong");
   a_fill_word: assert property (pat_q && code_q[3:2] == 2'h0 &&
      code_q[1] != code_q[0] |=> SAMPLE_A_OUT == {14{$past(code_q[1])}})
      else $error("fill word wrong");
   a_sine_period: assert property (sine_on [*8] ##1 sine_on |=>
      SAMPLE_A_OUT == $past(SAMPLE_A_OUT, 8)) else $error("sine not periodic");
endmodule
bind tpg_top tpg_top_properties tpg_top_properties_inst (.CLK_SYS(CLK_SYS),
   .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_A_IN(SAMPLE_A_IN),
   .SAMPLE_B_IN(SAMPLE_B_IN), .SAMPLE_A_OUT(SAMPLE_A_OUT),
   .SAMPLE_B_OUT(SAMPLE_B_OUT));
`default_nettype wire

// ---- testbench/test_tpg_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_tpg_top;
   localparam logic [9:0] ADDR [9] = '{10'h00C, 10'h010, 10'h018, 10'h028,
      10'h02C, 10'h030, 10'h034, 10'h038, 10'h03C};
   localparam logic [7:0] MASK [9] = '{8'h02, 8'h02, 8'h02, 8'h0F, 8'hF0,
      8'h0F, 8'hF0, 8'hFF, 8'hFC};
   localparam logic [13:0] SINE [8] = '{14'h0000, 14'h095F, 14'h2000,
      14'h36A0, 14'h3FFF, 14'h36A0, 14'h2000, 14'h095F};
   localparam logic [3:0] PATS [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h8, 4'h9, 4'h0};
   logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, pat_en;
   logic [9:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0] PSTRB, strb, code;
   logic [13:0] SAMPLE_A_IN, SAMPLE_B_IN, SAMPLE_A_OUT, SAMPLE_B_OUT;
   logic [13:0] prev_a, prev_b, cust;
   logic [13:0] last [2];
   logic [3:0] gc [2];
   logic ge [2];
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int si [2];
   bit first;
   tpg_top tpg_top_inst (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SAMPLE_A_IN(SAMPLE_A_IN), .SAMPLE_B_IN(SAMPLE_B_IN),
      .SAMPLE_A_OUT(SAMPLE_A_OUT), .SAMPLE_B_OUT(SAMPLE_B_OUT));
   tpg_sample_src tpg_sample_src_inst (.clk(CLK_SYS), .sample_a(SAMPLE_A_IN),
      .sample_b(SAMPLE_B_IN), .prev_a(prev_a), .prev_b(prev_b));
   initial begin
      CLK_SYS = 1'h0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   // ==========
   // reporting
   task check(input string name, input logic [31:0] seen,
         input logic [31:0] x);
      comparisons++;
      if (seen !== x) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, x, seen);
      end
   endtask
   task end_sim;
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles > 40000) begin
         n_fail++;
         end_sim();
      end
   end
   // ==========
   // bus master; waits on ready, never assumes the wait length
   task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      PSEL <= 1'h1;
      PENABLE <= 1'h0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h000000, d};
      PSTRB <= strb;
      @(posedge CLK_SYS);
      PENABLE <= 1'h1;
      do begin
         @(posedge CLK_SYS);
      end while (PREADY !== 1'h1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask
   task rdchk(input logic [9:0] a, input logic [7:0] x);
      apb(1'h0, a, 8'h00);
      check("register", rd, {24'h000000, x});
   endtask
   task setcfg(input logic [3:0] c, input logic p, input logic ga,
         input logic gb, input logic [3:0] ka, input logic [3:0] kb);
      apb(1'h1, 10'h018, {6'h00, p, 1'h0});
      apb(1'h1, 10'h028, {4'h0, c});
      apb(1'h1, 10'h02C, {c, 4'h0});
      apb(1'h1, 10'h00C, {6'h00, ga, 1'h0});
      apb(1'h1, 10'h010, {6'h00, gb, 1'h0});
      apb(1'h1, 10'h030, {4'h0, ka});
      apb(1'h1, 10'h034, {kb, 4'h0});
      code = c;
      pat_en = p;
      ge[0] = ga;
      ge[1] = gb;
      gc[0] = ka;
      gc[1] = kb;
      si[0] = -1;
      si[1] = -1;
      first = 1;
   endtask
   // ==========
   // expectations
   function automatic logic [13:0] gain(input logic [13:0] s,
         input logic [3:0] g, input logic en);
      int f;
      int p;
      if (!en) begin
         return s;
      end
      f = $rtoi(10.0 ** ((g > 12 ? 12 : g) / 40.0) * 4096.0 + 0.5);
      p = ($signed(s) * f) >>> 12;
      p = p > 8191 ? 8191 : (p < -8192 ? -8192 : p);
      return p[13:0];
   endfunction
   task samples(input int n);
      logic [13:0] out, in, e;
      repeat (n) begin
         @(posedge CLK_SYS);
         #1;
         for (int c = 0; c < 2; c++) begin
            out = c ? SAMPLE_B_OUT : SAMPLE_A_OUT;
            in = c ? prev_b : prev_a;
            e = gain(in, gc[c], ge[c]);
            if (pat_en) begin
               case (code)
                  4'h1: e = 14'h0000;
                  4'h2: e = 14'h3FFF;
                  4'h3: e = first ? (out[13] ? 14'h2AAA : 14'h1555) :
                     ~last[c];
                  4'h4: e = first ? out : last[c] + 14'h0001;
                  4'h5: e = cust;
                  4'h6: e = 14'h3AAA;
                  4'h8: e = c ? SAMPLE_A_OUT : (out == last[c] ? ~out : out);
                  4'h9: begin
                     si[c] = si[c] >= 0 ? (si[c] + 1) % 8 : si[c];
                     si[c] = out == 14'h0000 && si[c] < 0 ? 0 : si[c];
                     si[c] = out == 14'h3FFF && si[c] < 0 ? 4 : si[c];
                     // phase unknown until 0 or full scale: membership only
                     e = out == SINE[1] || out == SINE[2] ||
                        out == SINE[3] ? out : 14'h3FFF;
                     e = si[c] >= 0 ? SINE[si[c]] : e;
                  end
                  default: e = e;
               endcase
            end
            check("sample", {18'h00000, out}, {18'h00000, e});
            last[c] = out;
         end
         first = 0;
      end
   endtask
   // ==========
   // main sequence
   initial begin
      RST = 1'h1;
      PSEL = 1'h0;
      PENABLE = 1'h0;
      PWRITE = 1'h0;
      PADDR = 10'h000;
      PWDATA = 32'h00000000;
      PSTRB = 4'hF;
      strb = 4'hF;
      pat_en = 1'h0;
      code = 4'h0;
      cust = 14'h0000;
      void'($urandom(32'h5FEF07BB));
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'h0;
      for (int i = 0; i < 9; i++) begin
         rdchk(ADDR[i], 8'h00);
      end
      apb(1'h0, 10'h044, 8'h00);
      check("unmapped", {rd[30:0], er}, 32'h00000001);
      apb(1'h1, 10'h029, 8'hFF);
      check("unaligned", {31'h00000000, er}, 32'h00000001);
      rdchk(10'h028, 8'h00);
      for (int i = 0; i < 9; i++) begin
         apb(1'h1, ADDR[i], i == 2 ? 8'hFE : 8'hFF);
         rdchk(ADDR[i], MASK[i]);
      end
      strb = 4'hE;
      apb(1'h1, 10'h038, 8'h00);
      strb = 4'hF;
      rdchk(10'h038, 8'hFF);
      apb(1'h1, 10'h018, 8'h01);
      rdchk(10'h038, 8'h00);
      // gain on normal data, every step on A; B in opposite order, gain enabled only on odd g
      for (int g = 0; g < 13; g++) begin
         setcfg(4'h0, 1'h0, 1'h1, g[0], g[3:0], 4'hC - g[3:0]);
         samples(16);
      end
      rd = $urandom;
      cust = rd[13:0];
      apb(1'h1, 10'h038, cust[13:6]);
      apb(1'h1, 10'h03C, {cust[5:0], 2'h0});
      // every defined code on both channels, gain on to show patterns bypass it and code 0 applies it
      for (int i = 0; i < 9; i++) begin
         rd = $urandom_range(12);
         setcfg(PATS[i], 1'h1, 1'h1, 1'h1, rd[3:0], 4'hC - rd[3:0]);
         samples(24);
      end
      setcfg(4'h6, 1'h0, 1'h0, 1'h0, 4'h0, 4'h0);
      samples(8);
      // long enough to pass the ramp wrap at least once
      setcfg(4'h4, 1'h1, 1'h0, 1'h0, 4'h0, 4'h0);
      samples(16400);
      end_sim();
   end
endmodule
`default_nettype wire
